// ---- design/pcg_consts.vh ----
// Constants for the port C style GPIO block: register indices,
// byte addresses, reset values, bus answers and DMA setting field positions.
// Assumes inclusion by bare name from the design file.
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// Register indices as printed, byte address is four times the index
`define PCG_IDX_DIR 16'hffd5
`define PCG_IDX_DATA 16'hffd7
`define PCG_ADDR_W 18
`define PCG_ADDR_DIR 18'h3_ff54
`define PCG_ADDR_DATA 18'h3_ff5c

// Reset values and the direction read value
`define PCG_DIR_RST 8'h00
`define PCG_DATA_RST 8'h00
`define PCG_DIR_READ 8'hff
`define PCG_PIN_RST 8'hff

// Bus answers
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

// DMA setting field positions: {src2a, src1a, src0a, src2b, src1b}
`define PCG_SEL_2A 4
`define PCG_SEL_1A 3
`define PCG_SEL_0A 2
`define PCG_SEL_2B 1
`define PCG_SEL_1B 0

`endif

// ---- design/pcg_port.v ----
// Eight-bit GPIO port with DMA, chip-select and interrupt sharing,
// registers reached over an AXI4-Lite slave.
// Assumes one 40 MHz clock, synchronous active-low reset, pins and the
// hardware standby level arriving asynchronously, DMA settings and
// chip selects arriving from logic on the same clock.
`include "pcg_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pcg_port (
  input wire i_clk,
  input wire i_rst_n,
  // AXI4-Lite slave
  input wire [`PCG_ADDR_W-1:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [`PCG_ADDR_W-1:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Standby level from the pin
  input wire i_hw_standby,
  // Port pins
  input wire [7:0] i_pin,
  output reg [7:0] o_pin,
  output reg [7:0] o_pin_oe,
  // Chip selects seven down to four from the bus controller
  input wire [3:0] i_chip_select_n,
  // DMA controller settings, channel three and two
  input wire [4:0] i_dma3_sel,
  input wire [4:0] i_dma2_sel,
  input wire i_dma_end_three_n,
  input wire i_dma_end_two_n,
  output reg o_dma_req_three_n,
  output reg o_dma_req_two_n,
  output reg o_ext_int_seven_n,
  output reg o_ext_int_six_n
);

  // ----------------------------------------------------------------
  // Setting decoders
  // ----------------------------------------------------------------

  // External request taken from the pin for this setting
  function req_sel;
    input [4:0] s;
    reg both;
    begin
      both = s[`PCG_SEL_2A] & s[`PCG_SEL_1A];
      req_sel = (s[`PCG_SEL_2B] & s[`PCG_SEL_1B]) |
                (both & ~s[`PCG_SEL_0A] & s[`PCG_SEL_2B]);
    end
  endfunction

  // Transfer-end output driven onto the pin for this setting
  function end_sel;
    input [4:0] s;
    reg both;
    begin
      both = s[`PCG_SEL_2A] & s[`PCG_SEL_1A];
      end_sel = s[`PCG_SEL_2B] & (~s[`PCG_SEL_1B] | (both & s[`PCG_SEL_0A]));
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  reg [7:0] pin_s1_reg; // First stage, read only by the second
  reg [7:0] pin_s2_reg; // Second stage
  reg [7:0] pin_s3_reg; // Third stage
  reg [7:0] pin_lvl_reg; // Accepted pin level
  reg [7:0] pin_lvl_next;
  reg stby_s1_reg; // First stage of standby level
  reg stby_s2_reg;
  reg stby_s3_reg;
  reg stby_reg; // Accepted standby level
  reg stby_next;

  // Three-stage chains, no reset needed on the data path stages
  always @(posedge i_clk) begin
    pin_s1_reg <= i_pin;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
    stby_s1_reg <= i_hw_standby;
    stby_s2_reg <= stby_s1_reg;
    stby_s3_reg <= stby_s2_reg;
  end

  // Level accepted per bit once stages two and three agree
  always @* begin
    pin_lvl_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
                   (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
    stby_next = (stby_s2_reg == stby_s3_reg) ? stby_s2_reg : stby_reg;
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_lvl_reg <= `PCG_PIN_RST; // Idle high, no false interrupt edge
      stby_reg <= 1'b0;
    end else begin
      pin_lvl_reg <= pin_lvl_next;
      stby_reg <= stby_next;
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------

  reg [7:0] dir_reg; // Direction, one bit per pin
  reg [7:0] data_reg; // Stored output data
  reg [7:0] dir_next;
  reg [7:0] data_next;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------

  reg aw_have_reg; // Write address held
  reg w_have_reg; // Write data held
  reg [`PCG_ADDR_W-1:0] aw_addr_reg;
  reg [7:0] w_byte_reg;
  reg w_lane_reg; // Low byte lane enabled
  reg aw_have_next;
  reg w_have_next;
  reg [`PCG_ADDR_W-1:0] aw_addr_next;
  reg [7:0] w_byte_next;
  reg w_lane_next;
  reg bvalid_next;
  reg [1:0] bresp_next;
  reg do_write;

  // Address and data taken in either order, response after both
  always @* begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = o_bvalid;
    bresp_next = o_bresp;
    dir_next = dir_reg;
    data_next = data_reg;
    do_write = 1'b0;
    if (o_bvalid && i_bready) begin
      bvalid_next = 1'b0; // Response taken
    end
    if (i_awvalid && o_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_have_next = 1'b1;
      w_byte_next = i_wdata[7:0];
      w_lane_next = i_wstrb[0];
    end
    if (aw_have_reg && w_have_reg && !o_bvalid) begin
      do_write = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `PCG_RESP_OKAY;
      case (aw_addr_reg)
        `PCG_ADDR_DIR: begin
          if (w_lane_reg) dir_next = w_byte_reg;
        end
        `PCG_ADDR_DATA: begin
          if (w_lane_reg) data_next = w_byte_reg;
        end
        default: begin
          bresp_next = `PCG_RESP_SLVERR; // Unmapped address
        end
      endcase
    end
    if (stby_reg) begin
      dir_next = `PCG_DIR_RST;
      data_next = `PCG_DATA_RST;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= {`PCG_ADDR_W{1'b0}};
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `PCG_RESP_OKAY;
      dir_reg <= `PCG_DIR_RST;
      data_reg <= `PCG_DATA_RST;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      o_awready <= !aw_have_next && !bvalid_next && !do_write;
      o_wready <= !w_have_next && !bvalid_next && !do_write;
      o_bvalid <= bvalid_next;
      o_bresp <= bresp_next;
      dir_reg <= dir_next;
      data_reg <= data_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  reg [31:0] rdata_next;
  reg [1:0] rresp_next;
  reg rvalid_next;
  reg arready_next;

  // One read under way; answer one cycle after the address is taken
  always @* begin
    rdata_next = o_rdata;
    rresp_next = o_rresp;
    rvalid_next = o_rvalid;
    arready_next = o_arready;
    if (o_rvalid && i_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (i_arvalid && o_arready) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = `PCG_RESP_OKAY;
      case (i_araddr)
        `PCG_ADDR_DIR: begin
          rdata_next = {24'h00_0000, `PCG_DIR_READ};
        end
        `PCG_ADDR_DATA: begin
          // Stored bit where output, pin level where input
          rdata_next = {24'h00_0000, (dir_reg & data_reg) |
                        (~dir_reg & pin_lvl_reg)};
        end
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `PCG_RESP_SLVERR;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `PCG_RESP_OKAY;
    end else begin
      o_arready <= arready_next;
      o_rvalid <= rvalid_next;
      o_rdata <= rdata_next;
      o_rresp <= rresp_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin function selection, same in every mode
  // ----------------------------------------------------------------

  reg [7:0] pin_next;
  reg [7:0] oe_next;
  reg end3_on; // Pin 4 carries channel three transfer end
  reg end2_on; // Pin 2 carries channel two transfer end

  // Direction and DMA settings choose each pin's driver
  always @* begin
    end3_on = end_sel(i_dma3_sel);
    end2_on = end_sel(i_dma2_sel);
    oe_next = dir_reg;
    pin_next = data_reg;
    pin_next[5:2] = i_chip_select_n;
    if (end3_on) begin
      oe_next[4] = 1'b1;
      pin_next[4] = i_dma_end_three_n;
    end
    if (end2_on) begin
      oe_next[2] = 1'b1;
      pin_next[2] = i_dma_end_two_n;
    end
  end

  // Registered pin drivers and signals toward other blocks
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pin <= 8'h00;
      o_pin_oe <= 8'h00;
      o_dma_req_three_n <= 1'b1;
      o_dma_req_two_n <= 1'b1;
      o_ext_int_seven_n <= 1'b1;
      o_ext_int_six_n <= 1'b1;
    end else begin
      o_pin <= pin_next;
      o_pin_oe <= oe_next;
      o_ext_int_seven_n <= pin_lvl_reg[7];
      o_ext_int_six_n <= pin_lvl_reg[6];
      // Requests idle high unless the setting picks the pin
      o_dma_req_three_n <= req_sel(i_dma3_sel) ? pin_lvl_reg[5] : 1'b1;
      o_dma_req_two_n <= req_sel(i_dma2_sel) ? pin_lvl_reg[3] : 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- bench/pcg_board.sv ----
// Board model: pin levels seen by the port.
// Assumes the testbench sets the level that the board drives.
`timescale 1ns/1ps
`default_nettype none
module pcg_board (
  input wire logic [7:0] i_drive,
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  output wire logic [7:0] o_level
);
  // Driven pins show the port, the rest the board
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_drive);
endmodule
`default_nettype wire

// ---- bench/pcg_port_assertions.sv ----
// Checker on the port's top pins.
// Assumes one clock and synchronous active-low reset.
`include "pcg_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pcg_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_hw_standby,
  input wire [7:0] i_pin,
  input wire [3:0] i_chip_select_n,
  input wire [4:0] i_dma3_sel,
  input wire [4:0] i_dma2_sel,
  input wire i_dma_end_three_n,
  input wire [17:0] i_araddr,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire [31:0] o_rdata,
  input wire [7:0] o_pin,
  input wire [7:0] o_pin_oe,
  input wire o_dma_req_three_n,
  input wire o_dma_req_two_n,
  input wire o_ext_int_seven_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Request and transfer-end decodes
  function automatic logic rqf(input logic [4:0] s);
    return (s[1] & s[0]) | (&s[4:3] & ~s[2] & s[1]);
  endfunction
  function automatic logic enf(input logic [4:0] s);
    return s[1] & (~s[0] | &s[4:2]);
  endfunction
  sequence pin_quiet;
    $stable(i_pin[7])[*7];
  endsequence
  sequence sel_quiet;
    $stable({i_dma3_sel, i_dma2_sel, i_dma_end_three_n})[*2];
  endsequence
  sequence ar_at(a);
    i_arvalid && o_arready && i_araddr == a;
  endsequence
  int_seven_a: assert property (pin_quiet |-> o_ext_int_seven_n == i_pin[7])
    else $error("interrupt level wrong");
  req_three_a: assert property (sel_quiet ##0 !rqf(i_dma3_sel) |-> o_dma_req_three_n)
    else $error("request three not idle");
  req_two_a: assert property (sel_quiet ##0 !rqf(i_dma2_sel) |-> o_dma_req_two_n)
    else $error("request two not idle");
  end_four_a: assert property (sel_quiet ##0 enf(i_dma3_sel) && !i_hw_standby
    |-> o_pin_oe[4] && o_pin[4] == i_dma_end_three_n) else $error("end pin wrong");
  cs_seven_a: assert property (o_pin_oe[5] |-> o_pin[5] == $past(i_chip_select_n[3]))
    else $error("select pin wrong");
  standby_off_a: assert property (i_hw_standby[*7] |-> (o_pin_oe & 8'heb) == 8'h00)
    else $error("standby left drivers on");
  dir_read_a: assert property (ar_at(`PCG_ADDR_DIR) |=> o_rvalid && o_rdata == 32'h0000_00ff)
    else $error("direction read wrong");
  out_read_a: assert property (ar_at(`PCG_ADDR_DATA) ##0 o_pin_oe[1] && $stable(o_pin[1])
    |=> o_rdata[1] == $past(o_pin[1])) else $error("output read wrong");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the port over its register bus.
// Assumes the board model and the bound checker.
`include "pcg_consts.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module testbench;
  logic i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_hw_standby = 0;
  logic i_dma_end_three_n = 0, i_dma_end_two_n = 0;
  logic [17:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, rv;
  logic [3:0] i_wstrb = 4'hf, i_chip_select_n = 4'hf;
  logic [4:0] i_dma3_sel = 0, i_dma2_sel = 0;
  logic [7:0] drv = 8'ha5;
  logic [1:0] rs;
  wire [7:0] i_pin, o_pin, o_pin_oe;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dma_req_three_n;
  wire o_dma_req_two_n, o_ext_int_seven_n, o_ext_int_six_n;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  int bad_count = 0, tests_run = 0;
  logic rq, en;
  pcg_port dut_u (.*);
  pcg_board brd_u (.i_drive(drv), .i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .o_level(i_pin));
  initial forever #12.5 i_clk = ~i_clk;
  // Bus write, response code left in rs
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    bit busy;
    busy = 1;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    while (busy) begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      if (o_bvalid) begin
        rs = o_bresp;
        i_bready <= 0;
        busy = 0;
      end
    end
  endtask
  // Bus read, data in rv and code in rs
  task automatic rd(input logic [17:0] a);
    bit busy;
    busy = 1;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    while (busy) begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
      if (o_rvalid) begin
        rv = o_rdata;
        rs = o_rresp;
        i_rready <= 0;
        busy = 0;
      end
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well past the expected run of under a thousand cycles
  initial begin
    #100us;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1;
    settle;
    rd(`PCG_ADDR_DIR);
    `CHK(rv[7:0], `PCG_DIR_READ)
    `CHK(o_pin_oe, 8'h00)
    wr(`PCG_ADDR_DATA, 8'h5a);
    rd(`PCG_ADDR_DATA);
    `CHK(rv[7:0], 8'ha5)
    wr(`PCG_ADDR_DIR, 8'hc3);
    rd(`PCG_ADDR_DATA);
    `CHK(rv[7:0], 8'h66)
    `CHK(o_pin_oe, 8'hc3)
    `CHK(o_pin & 8'hc3, 8'h42)
    i_chip_select_n <= 4'b1010;
    wr(`PCG_ADDR_DIR, 8'hff);
    @(negedge i_clk);
    `CHK(o_pin[5:2], 4'b1010)
    `CHK(o_pin_oe, 8'hff)
    wr(18'h0_0010, 8'h11);
    `CHK(rs, `PCG_RESP_SLVERR)
    rd(18'h0_0010);
    `CHK({rs, rv}, {`PCG_RESP_SLVERR, 32'h0})
    rd(`PCG_ADDR_DATA);
    `CHK(rv[7:0], 8'h5a)
    wr(`PCG_ADDR_DIR, 8'h00);
    drv <= 8'h57;
    settle;
    // Every DMA setting, pins 5 and 3 held low
    for (int s = 0; s < 32; s++) begin
      i_dma3_sel <= s[4:0];
      i_dma2_sel <= s[4:0];
      i_dma_end_three_n <= s[0];
      i_dma_end_two_n <= ~s[0];
      rq = (s[1] & s[0]) | (s[4] & s[3] & ~s[2] & s[1]);
      en = s[1] & (~s[0] | (s[4] & s[3] & s[2]));
      repeat (3) @(posedge i_clk);
      `CHK({o_dma_req_three_n, o_dma_req_two_n, o_pin_oe[4], o_pin_oe[2]}, {~rq, ~rq, en, en})
      `CHK({o_pin[4], o_pin[2]}, en ? {s[0], ~s[0]} : 2'b00)
      `CHK({o_ext_int_seven_n, o_ext_int_six_n}, 2'b01)
    end
    wr(`PCG_ADDR_DATA, 8'hff);
    wr(`PCG_ADDR_DIR, 8'hff);
    i_hw_standby <= 1;
    settle;
    i_hw_standby <= 0;
    settle;
    `CHK(o_pin_oe & 8'heb, 8'h00)
    wr(`PCG_ADDR_DIR, 8'hff);
    rd(`PCG_ADDR_DATA);
    `CHK(rv[7:0], 8'h00)
    test_done;
  end
endmodule
bind pcg_port pcg_chk chk_u (.*);
`default_nettype wire
